/* File: hdl/exec_params.svh */
/*
 * timing counts and field positions for the return/rotate/subtract execution block.
 * assumes inclusion by bare name from design files.
 */
`ifndef EXEC_PARAMS_SVH
`define EXEC_PARAMS_SVH
`define RET_CYCLES 2'd2
`define FLAG_CARRY 0
`define FLAG_HALF 1
`define FLAG_ZERO 2
`define DEST_WORK 1'b0
`define DEST_FILE 1'b1
`define STACK_DEPTH 8
`define STACK_PTR_W 4
`define PC_W 11
`define WORK_RESET 8'h00
`define FLAGS_RESET 3'h0
`endif

/* File: hdl/exec_pkg.sv */
/*
 * types shared by the execution block.
 * assumes nothing beyond a systemverilog compiler.
 */
package exec_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SUBROUTINE_RETURN = 3'h1,
        OP_ROTATE_RIGHT = 3'h2,
        OP_REG_SBC = 3'h3,
        OP_IMM_SBC = 3'h4
    } op_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RET2 = 2'b01
    } state_t;
endpackage

/* File: hdl/return_rotate_subtract_exec.sv */
/*
 * executes subroutine return, rotate right through carry and both subtract-with-borrow forms.
 * assumes decoded op, operands and file read data arrive on clk_sys, stable while busy is high.
 */
`include "exec_params.svh"
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - return loads pc from stack top, pops once, flags kept, two cycles
// - rotate right: old carry to bit7, bits7..1 down, bit0 to carry
// - rotate and register subtract: dest 0 working register, 1 file register
// - register subtract: file + ~working + carry, flags z dc c, one cycle
// - immediate subtract: imm + ~working + carry into working register, one cycle
module return_rotate_subtract_exec (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic start,
    input wire exec_pkg::op_t op,
    input wire logic dest_bit,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] imm,
    input wire logic call_push,
    input wire logic [`PC_W-1:0] call_addr,
    output logic busy,
    output logic done,
    output logic [7:0] working_register,
    output logic file_we,
    output logic [7:0] file_wdata,
    output logic [`PC_W-1:0] pc,
    output logic pc_load,
    output logic carry_flag,
    output logic half_carry_flag,
    output logic zero_flag,
    output logic [`STACK_PTR_W-1:0] stack_level
);
    // sequencing
    exec_pkg::state_t state_r;
    exec_pkg::state_t state_nxt;
    logic done_r;
    logic done_nxt;
    logic pcl_r;
    logic pcl_nxt;
    // working register and file write-back
    logic [7:0] work_r;
    logic [7:0] work_nxt;
    logic [7:0] fwd_r;
    logic [7:0] fwd_nxt;
    logic fwe_r;
    logic fwe_nxt;
    // status flags, one bit at each flag position
    logic [2:0] flags_r;
    logic [2:0] flags_nxt;
    // call stack interface
    logic [`PC_W-1:0] top_addr;
    logic pop;
    // decode
    logic take;
    logic is_ret;
    logic is_rot;
    logic is_rsbc;
    logic is_isbc;
    logic is_sbc;
    logic writes_dest;
    logic to_file;
    // datapath
    logic carry_in;
    logic [7:0] src;
    logic [7:0] inv_work;
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] rot_res;
    logic [7:0] res;
    logic zero_res;

    // a start offered while busy is dropped with no indication
    assign take = start && state_r == exec_pkg::ST_IDLE;
    assign is_ret = op == exec_pkg::OP_SUBROUTINE_RETURN;
    assign is_rot = op == exec_pkg::OP_ROTATE_RIGHT;
    assign is_rsbc = op == exec_pkg::OP_REG_SBC;
    assign is_isbc = op == exec_pkg::OP_IMM_SBC;
    assign is_sbc = is_rsbc || is_isbc;
    assign writes_dest = is_rot || is_rsbc;
    assign to_file = writes_dest && dest_bit == `DEST_FILE;
    assign pop = take && is_ret;
    assign carry_in = flags_r[`FLAG_CARRY];

    return_stack return_stack_inst (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .push(call_push),
        .push_addr(call_addr),
        .pop(pop),
        .top_addr(top_addr),
        .level(stack_level)
    );

    // datapath shared by all arithmetic ops
    always_comb begin
        src = is_isbc ? imm : file_rdata;
        inv_work = ~work_r;
        sum = {1'b0, src} + {1'b0, inv_work} + {8'h00, carry_in};
        // low nibble summed apart so its carry-out needs no extra tap
        low = {1'b0, src[3:0]} + {1'b0, inv_work[3:0]} + {4'h0, carry_in};
        rot_res = {carry_in, file_rdata[7:1]};
        res = is_rot ? rot_res : sum[7:0];
        zero_res = sum[7:0] == 8'h00;
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            exec_pkg::ST_IDLE: begin
                if (pop) begin
                    state_nxt = exec_pkg::ST_RET2;
                end
            end
            exec_pkg::ST_RET2: begin
                state_nxt = exec_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = exec_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_r <= exec_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_comb begin
        done_nxt = 1'b0;
        pcl_nxt = 1'b0;
        if (take && (is_rot || is_sbc)) begin
            done_nxt = 1'b1;
        end
        // the second return cycle loads pc and reports completion
        if (state_r == exec_pkg::ST_RET2) begin
            done_nxt = 1'b1;
            pcl_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            done_r <= 1'b0;
            pcl_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
            pcl_r <= pcl_nxt;
        end
    end

    always_comb begin
        work_nxt = work_r;
        fwd_nxt = fwd_r;
        fwe_nxt = 1'b0;
        if (take && writes_dest) begin
            if (to_file) begin
                fwd_nxt = res;
                fwe_nxt = 1'b1;
            end else begin
                work_nxt = res;
            end
        end else if (take && is_isbc) begin
            work_nxt = res;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            work_r <= `WORK_RESET;
            fwd_r <= `WORK_RESET;
            fwe_r <= 1'b0;
        end else begin
            work_r <= work_nxt;
            fwd_r <= fwd_nxt;
            fwe_r <= fwe_nxt;
        end
    end

    always_comb begin
        flags_nxt = flags_r;
        if (take && is_sbc) begin
            flags_nxt[`FLAG_CARRY] = sum[8];
            flags_nxt[`FLAG_HALF] = low[4];
            flags_nxt[`FLAG_ZERO] = zero_res;
        end else if (take && is_rot) begin
            flags_nxt[`FLAG_CARRY] = file_rdata[0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flags_r <= `FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign busy = state_r != exec_pkg::ST_IDLE;
    assign done = done_r;
    assign pc_load = pcl_r;
    assign pc = top_addr;
    assign working_register = work_r;
    assign file_we = fwe_r;
    assign file_wdata = fwd_r;
    assign carry_flag = flags_r[`FLAG_CARRY];
    assign half_carry_flag = flags_r[`FLAG_HALF];
    assign zero_flag = flags_r[`FLAG_ZERO];
endmodule
`default_nettype wire

/* File: hdl/return_stack.sv */
/*
 * call stack storage; read data registered.
 * assumes push and pop never in the same cycle.
 */
`include "exec_params.svh"
`timescale 1ns/100ps
`default_nettype none
module return_stack (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic push,
    input wire logic [`PC_W-1:0] push_addr,
    input wire logic pop,
    output logic [`PC_W-1:0] top_addr,
    output logic [`STACK_PTR_W-1:0] level
);
    logic [`PC_W-1:0] mem [0:`STACK_DEPTH-1];
    logic [`STACK_PTR_W-1:0] level_r;
    logic [`PC_W-1:0] top_r;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;

    assign wr_idx = level_r[2:0];
    assign rd_idx = level_r[2:0] - 3'h1;
    assign level = level_r;
    assign top_addr = top_r;

    always_ff @(posedge clk_sys) begin
        if (push && level_r < `STACK_PTR_W'(`STACK_DEPTH)) begin
            mem[wr_idx] <= push_addr;
        end
    end

    // underflow holds at zero rather than wrapping
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            level_r <= '0;
        end else if (push && level_r < `STACK_PTR_W'(`STACK_DEPTH)) begin
            level_r <= level_r + `STACK_PTR_W'(1);
        end else if (pop && level_r != '0) begin
            level_r <= level_r - `STACK_PTR_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            top_r <= '0;
        end else if (pop && level_r != '0) begin
            top_r <= mem[rd_idx];
        end
    end
endmodule
`default_nettype wire

/* File: tb/exec_chk_sva.sv */
/* assertions on the execution block's ports.
   assumes ops are taken on a rising edge with start high and busy low. */
`timescale 1ns/100ps
`default_nettype none
module exec_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic start,
    input wire exec_pkg::op_t op,
    input wire logic dest_bit,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] imm,
    input wire logic busy,
    input wire logic [7:0] working_register,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    input wire logic pc_load,
    input wire logic carry_flag,
    input wire logic half_carry_flag,
    input wire logic zero_flag
);
    logic go, ret, rot, sbc;
    logic [7:0] src;
    logic [8:0] s9;
    logic [4:0] h5;
    assign go = start && !busy;
    assign ret = go && op == 3'h1;
    assign rot = go && op == 3'h2;
    assign sbc = go && (op == 3'h3 || op == 3'h4);
    assign src = (op == 3'h4) ? imm : file_rdata;
    assign s9 = {1'b0, src} + {1'b0, ~working_register} + {8'h00, carry_flag};
    assign h5 = {1'b0, src[3:0]} + {1'b0, ~working_register[3:0]} + {4'h0, carry_flag};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    ret_two_cycle_a: assert property (ret |=> busy ##1 pc_load)
        else $error("return timing wrong");
    ret_flags_kept_a: assert property (ret |=> $stable({carry_flag, half_carry_flag, zero_flag}) [*2])
        else $error("return changed flags");
    rot_carry_a: assert property (rot |=> carry_flag == $past(file_rdata[0]))
        else $error("rotate carry wrong");
    rot_dest_a: assert property (rot |=> file_we == $past(dest_bit)
        && (file_we ? file_wdata : working_register)
        == {$past(carry_flag), $past(file_rdata[7:1])}) else $error("rotate result wrong");
    sbc_result_a: assert property (sbc |=> file_we == $past(dest_bit && op == 3'h3)
        && (file_we ? file_wdata : working_register) == $past(s9[7:0]))
        else $error("subtract result wrong");
    sbc_flags_a: assert property (sbc |=> {carry_flag, half_carry_flag, zero_flag}
        == $past({s9[8], h5[4], s9[7:0] == 8'h00})) else $error("subtract flags wrong");
    cover property (ret ##2 ret);
    cover property (sbc && dest_bit);
    cover property (rot);
endmodule
bind return_rotate_subtract_exec exec_chk exec_chk_inst (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .start(start),
    .op(op),
    .dest_bit(dest_bit),
    .file_rdata(file_rdata),
    .imm(imm),
    .busy(busy),
    .working_register(working_register),
    .file_we(file_we),
    .file_wdata(file_wdata),
    .pc_load(pc_load),
    .carry_flag(carry_flag),
    .half_carry_flag(half_carry_flag),
    .zero_flag(zero_flag)
);
`default_nettype wire

/* File: tb/tb.sv */
/* self-checking bench for the execution block.
   assumes the design and checker files are compiled first. */
`include "exec_params.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk_sys, rstn, start, dest_bit, call_push, busy, done, file_we, pc_load;
    logic carry_flag, half_carry_flag, zero_flag;
    exec_pkg::op_t op;
    logic [7:0] file_rdata, imm, working_register, file_wdata;
    logic [`PC_W-1:0] call_addr, pc;
    logic [`STACK_PTR_W-1:0] stack_level;
    int err_total = 0;
    int n_compared = 0;
    return_rotate_subtract_exec return_rotate_subtract_exec_inst (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .start(start),
        .op(op),
        .dest_bit(dest_bit),
        .file_rdata(file_rdata),
        .imm(imm),
        .call_push(call_push),
        .call_addr(call_addr),
        .busy(busy),
        .done(done),
        .working_register(working_register),
        .file_we(file_we),
        .file_wdata(file_wdata),
        .pc(pc),
        .pc_load(pc_load),
        .carry_flag(carry_flag),
        .half_carry_flag(half_carry_flag),
        .zero_flag(zero_flag),
        .stack_level(stack_level)
    );
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic flags(input logic [2:0] e);
        chk("flags", {carry_flag, half_carry_flag, zero_flag}, e);
    endtask
    // one request pulse; returns in the cycle after it is taken
    task automatic go(input int o, d, f, i);
        @(posedge clk_sys) #1;
        start = 1;
        op = exec_pkg::op_t'(o[2:0]);
        dest_bit = d[0];
        file_rdata = f[7:0];
        imm = i[7:0];
        @(posedge clk_sys) #1;
        start = 0;
    endtask
    task automatic t_rot;
        go(2, 0, 8'ha5, 0);
        chk("wreg", {file_we, working_register}, 9'h052);
        flags(3'b100);
        chk("done", done, 1'b1);
        go(2, 1, 8'ha5, 0);
        chk("wdata", {file_we, file_wdata}, 9'h1d2);
        chk("wreg", working_register, 8'h52);
    endtask
    task automatic t_sbc;
        // carry is still set by the rotate tests; two rotates leave 06 with carry clear
        go(2, 0, 8'h0c, 0);
        go(2, 0, 8'h0c, 0);
        go(3, 1, 8'h05, 0);
        chk("wdata", {file_we, file_wdata}, 9'h1fe);
        flags(3'b000);
        go(2, 0, 8'h0a, 0);
        go(4, 1, 8'hff, 8'h06);
        chk("wreg", {file_we, working_register}, 9'h000);
        flags(3'b111);
        go(3, 0, 8'h05, 0);
        chk("wreg", {file_we, working_register}, 9'h005);
        flags(3'b110);
    endtask
    task automatic t_ret;
        @(posedge clk_sys) #1;
        call_push = 1;
        call_addr = 11'h123;
        @(posedge clk_sys) #1;
        call_addr = 11'h456;
        @(posedge clk_sys) #1;
        call_push = 0;
        start = 1;
        op = exec_pkg::OP_SUBROUTINE_RETURN;
        @(posedge clk_sys) #1;
        chk("busy", {busy, stack_level}, 5'h11);
        // a rotate offered while busy must be ignored
        op = exec_pkg::OP_ROTATE_RIGHT;
        @(posedge clk_sys) #1;
        chk("pc", {pc_load, done, pc}, 13'h1c56);
        chk("wreg", working_register, 8'h05);
        flags(3'b110);
        op = exec_pkg::OP_SUBROUTINE_RETURN;
        @(posedge clk_sys) #1;
        start = 0;
        @(posedge clk_sys) #1;
        chk("pc", {pc_load, stack_level, pc}, 16'h8123);
    endtask
    task automatic conclude;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        {rstn, start, dest_bit, call_push, file_rdata, imm, call_addr} = 0;
        op = exec_pkg::OP_NONE;
        repeat (20) @(posedge clk_sys);
        #1 rstn = 1;
        t_rot;
        t_sbc;
        t_ret;
        conclude;
    end
    initial begin
        #100000;
        err_total++;
        conclude;
    end
endmodule
`default_nettype wire
